// >>> rtl/acc_map.vh
// Purpose: Register map, field positions and timing counts of the converter control block
// Assumes: APB byte addresses, one 32-bit word per register
// Notes:   Definitions only
`ifndef ACC_MAP_VH
`define ACC_MAP_VH

// ==========================================================
// Register byte addresses
`define ACC_ADDR_W          4
`define ACC_OFF_STATUS_CTRL 4'h0
`define ACC_OFF_CLOCK_CFG   4'h4
`define ACC_OFF_RESULT_HIGH 4'h8
`define ACC_OFF_RESULT_LOW  4'hC

// ==========================================================
// Status/control fields
`define ACC_SC_CHAN_LSB     0
`define ACC_SC_CHAN_MSB     4
`define ACC_SC_CONT_BIT     5
`define ACC_SC_DONE_BIT     7
`define ACC_SC_RESET        8'h1F

// ==========================================================
// Clock configuration fields
`define ACC_CK_TEN_BIT      0
`define ACC_CK_LONG_BIT     1
`define ACC_CK_AEN_BIT      2
`define ACC_CK_SRC_BIT      3
`define ACC_CK_DIV_LSB      4
`define ACC_CK_DIV_MSB      5
`define ACC_CK_MASK         8'h3F
`define ACC_CK_RESET        8'h01

// ==========================================================
// Channel codes
`define ACC_CH_PORT_B_ZERO  5'h04
`define ACC_CH_PORT_B_ONE   5'h05
`define ACC_CH_BANDGAP      5'h1A
`define ACC_CH_OFF          5'h1F

// ==========================================================
// Sample phase lengths less one, in conversion clock ticks
`define ACC_SAMPLE_SHORT    5'h03
`define ACC_SAMPLE_LONG     5'h13

// ==========================================================
// Internal asynchronous clock divide default
`define ACC_ASYNC_DIV       8
`define ACC_TOP_BIT         4'h9
`define ACC_LOW_BIT_10      4'h0
`define ACC_LOW_BIT_8       4'h2

`endif

// >>> rtl/acc_sar.v
// Purpose: Successive approximation sequencer with sample phase
// Assumes: tick_i is a one-cycle enable at the conversion clock rate
// Notes:   Result is valid in the cycle done_o pulses
`timescale 1ns/1ps
`default_nettype none
`include "acc_map.vh"

module acc_sar (
   input  wire       clk_i,
   input  wire       rst_n_i,
   input  wire       tick_i,
   input  wire       start_i,
   input  wire       ten_bit_i,
   input  wire       long_i,
   input  wire       cmp_i,
   output reg  [9:0] dac_o,
   output reg        sample_o,
   output reg        busy_o,
   output reg        done_o,
   output wire [9:0] result_o
);

   localparam ST_IDLE   = 2'b00;
   localparam ST_SAMPLE = 2'b01;
   localparam ST_CONV   = 2'b10;

   reg [1:0] state_r;
   reg [4:0] cnt_r;
   reg [3:0] idx_r;
   reg       ten_r;

   wire [3:0] low_bit = ten_r ? `ACC_LOW_BIT_10 : `ACC_LOW_BIT_8;

   assign result_o = dac_o;

   // ==========================================================
   // Sequencer
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_r  <= ST_IDLE;
         cnt_r    <= 5'h00;
         idx_r    <= 4'h0;
         ten_r    <= 1'b1;
         dac_o    <= 10'h000;
         sample_o <= 1'b0;
         busy_o   <= 1'b0;
         done_o   <= 1'b0;
      end else begin
         done_o <= 1'b0;
         if (start_i) begin
            state_r  <= ST_SAMPLE;
            ten_r    <= ten_bit_i;
            cnt_r    <= long_i ? `ACC_SAMPLE_LONG : `ACC_SAMPLE_SHORT;
            dac_o    <= 10'h000;
            sample_o <= 1'b1;
            busy_o   <= 1'b1;
         end else if (tick_i) begin
            case (state_r)
               ST_SAMPLE: begin
                  if (cnt_r == 5'h00) begin
                     state_r  <= ST_CONV;
                     sample_o <= 1'b0;
                     idx_r    <= `ACC_TOP_BIT;
                     dac_o    <= 10'h200;
                  end else begin
                     cnt_r <= cnt_r - 5'h01;
                  end
               end
               ST_CONV: begin
                  // Keep the trial bit when the input is at or above the trial level
                  if (!cmp_i) begin
                     dac_o[idx_r] <= 1'b0;
                  end
                  if (idx_r == low_bit) begin
                     state_r <= ST_IDLE;
                     busy_o  <= 1'b0;
                     done_o  <= 1'b1;
                  end else begin
                     idx_r              <= idx_r - 4'h1;
                     dac_o[idx_r - 4'h1] <= 1'b1;
                  end
               end
               default: begin
                  state_r <= ST_IDLE;
                  busy_o  <= 1'b0;
               end
            endcase
         end
      end
   end

endmodule
`default_nettype wire

// >>> rtl/acc_top.v
// Purpose: Converter control: APB registers, clock selection, channel routing, result capture
// Assumes: clk_i is the x4 system clock; stop_i high while the processor is in stop mode
//          stop_i and cmp_i are already synchronous to clk_i
// Notes:   Analog mux and comparator sit outside; this block drives select and trial code
//          Writing status/control with a channel other than 1F during a conversion aborts it and starts afresh
//          A done set in the same cycle as a clearing write wins
//          Port B digital paths are never gated by the analog select
// Functional notes
// - The converter offers a 10-bit and an 8-bit resolution chosen by software.
// - The channel field routes an external analog input or the bandgap to the converter.
// - Two extra analog channels sit on port B lines zero and one.
// - Selecting a pin as analog channel leaves its digital I/O function untouched.
// - The conversion clock comes from the bus clock times four or an internal async clock.
// - In 10-bit mode the top two result bits go to the high register, the rest to low.
// - The long-sample bit lengthens the sample phase and so the conversion.
// - With the async clock enabled the internal clock runs and converts in stop mode.
// - Channel code 1A routes the bandgap reference to the converter.
`timescale 1ns/1ps
`default_nettype none
`include "acc_map.vh"

module acc_top #(
   parameter ASYNC_DIV = `ACC_ASYNC_DIV
) (
   input  wire        clk_i,
   input  wire        rst_n_i,
   input  wire        psel_i,
   input  wire        penable_i,
   input  wire        pwrite_i,
   input  wire [31:0] paddr_i,
   input  wire [31:0] pwdata_i,
   output reg  [31:0] prdata_o,
   output reg         pready_o,
   output reg         pslverr_o,
   input  wire        stop_i,
   input  wire        cmp_i,
   output reg  [4:0]  chan_sel_o,
   output reg         bandgap_sel_o,
   output reg  [1:0]  port_b_analog_o,
   output wire [9:0]  dac_o,
   output wire        sample_o,
   output wire        busy_o,
   output reg         done_o
);

   // ==========================================================
   // Registers
   // Status/control keeps bits 5:0; bit 7 reads the done flag
   reg [7:0] sc_r;
   reg [7:0] ck_r;
   reg [1:0] res_hi_r;
   reg [7:0] res_lo_r;
   reg       done_r;
   reg       start_r;

   wire [`ACC_ADDR_W-1:0] addr = paddr_i[`ACC_ADDR_W-1:0];
   wire mapped  = (paddr_i[31:`ACC_ADDR_W] == 28'h0000000);
   wire access  = psel_i & penable_i;
   wire commit  = access & pready_o;
   wire wr_sc   = commit & pwrite_i & mapped & (addr == `ACC_OFF_STATUS_CTRL);
   wire wr_ck   = commit & pwrite_i & mapped & (addr == `ACC_OFF_CLOCK_CFG);

   wire [4:0] chan    = sc_r[`ACC_SC_CHAN_MSB:`ACC_SC_CHAN_LSB];
   wire       ten_bit = ck_r[`ACC_CK_TEN_BIT];
   wire       long_s  = ck_r[`ACC_CK_LONG_BIT];
   wire       aclk_en = ck_r[`ACC_CK_AEN_BIT];
   wire       src_asy = ck_r[`ACC_CK_SRC_BIT];
   wire [1:0] div_sel = ck_r[`ACC_CK_DIV_MSB:`ACC_CK_DIV_LSB];

   wire [9:0] sar_res;
   wire       sar_done;

   // ==========================================================
   // Clock sources and divider
   reg  [7:0] async_cnt_r;
   reg        async_tick_r;
   reg  [2:0] div_cnt_r;
   reg        conv_tick_r;

   // Internal oscillator runs when enabled or selected; it ignores stop mode
   // It is modelled as a divided enable of clk_i
   wire async_run = aclk_en | src_asy;
   // Bus clock x4 halts in stop mode; an enabled internal clock then takes over
   wire use_async = src_asy | (aclk_en & stop_i);
   wire ref_tick  = use_async ? async_tick_r : ~stop_i;
   wire [2:0] div_max = (3'h1 << div_sel) - 3'h1;

   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         async_cnt_r  <= 8'h00;
         async_tick_r <= 1'b0;
         div_cnt_r    <= 3'h0;
         conv_tick_r  <= 1'b0;
      end else begin
         async_tick_r <= 1'b0;
         if (!async_run) begin
            async_cnt_r <= 8'h00;
         end else if (async_cnt_r == ASYNC_DIV[7:0] - 8'h01) begin
            async_cnt_r  <= 8'h00;
            async_tick_r <= 1'b1;
         end else begin
            async_cnt_r <= async_cnt_r + 8'h01;
         end
         conv_tick_r <= 1'b0;
         // Restart the divider so the first tick comes a full period after start
         if (start_r) begin
            div_cnt_r <= 3'h0;
         end else if (ref_tick) begin
            if (div_cnt_r >= div_max) begin
               div_cnt_r   <= 3'h0;
               conv_tick_r <= 1'b1;
            end else begin
               div_cnt_r <= div_cnt_r + 3'h1;
            end
         end
      end
   end

   // ==========================================================
   // Register file and conversion control
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sc_r     <= `ACC_SC_RESET;
         ck_r     <= `ACC_CK_RESET;
         res_hi_r <= 2'b00;
         res_lo_r <= 8'h00;
         done_r   <= 1'b0;
         start_r  <= 1'b0;
      end else begin
         start_r <= 1'b0;
         if (wr_ck) begin
            ck_r <= pwdata_i[7:0] & `ACC_CK_MASK;
         end
         // A start while busy aborts the running conversion
         if (wr_sc) begin
            sc_r    <= {2'b00, pwdata_i[`ACC_SC_CONT_BIT:0]};
            start_r <= (pwdata_i[`ACC_SC_CHAN_MSB:`ACC_SC_CHAN_LSB] != `ACC_CH_OFF);
         end else if (sar_done & sc_r[`ACC_SC_CONT_BIT] & (chan != `ACC_CH_OFF)) begin
            start_r <= 1'b1;
         end
         if (sar_done) begin
            // Both halves load in one edge so a read never mixes two conversions
            if (ten_bit) begin
               res_hi_r <= sar_res[9:8];
               res_lo_r <= sar_res[7:0];
            end else begin
               res_hi_r <= 2'b00;
               res_lo_r <= sar_res[9:2];
            end
            // Set wins over a clearing write in the same cycle
            done_r <= 1'b1;
         end else if (wr_sc) begin
            done_r <= 1'b0;
         end
      end
   end

   // ==========================================================
   // APB answer: pready in the second access cycle
   // Unmapped or unaligned addresses answer with pslverr and write nothing
   wire first_cyc = access & ~pready_o;
   wire aligned   = mapped & (addr[1:0] == 2'b00);

   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o  <= 32'h00000000;
      end else begin
         pready_o  <= first_cyc;
         pslverr_o <= first_cyc & ~aligned;
         // Read data stand only in the pready cycle
         prdata_o  <= 32'h00000000;
         if (first_cyc & ~pwrite_i & mapped) begin
            case (addr)
               `ACC_OFF_STATUS_CTRL: prdata_o <= {24'h000000, done_r, 1'b0, sc_r[5:0]};
               `ACC_OFF_CLOCK_CFG:   prdata_o <= {24'h000000, ck_r};
               `ACC_OFF_RESULT_HIGH: prdata_o <= {30'h00000000, res_hi_r};
               `ACC_OFF_RESULT_LOW:  prdata_o <= {24'h000000, res_lo_r};
               default:              prdata_o <= 32'h00000000;
            endcase
         end
      end
   end

   // ==========================================================
   // Analog routing: select lines only, port pin digital paths are not gated
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         chan_sel_o      <= `ACC_CH_OFF;
         bandgap_sel_o   <= 1'b0;
         port_b_analog_o <= 2'b00;
         done_o          <= 1'b0;
      end else begin
         chan_sel_o         <= chan;
         bandgap_sel_o      <= (chan == `ACC_CH_BANDGAP);
         port_b_analog_o[0] <= (chan == `ACC_CH_PORT_B_ZERO);
         port_b_analog_o[1] <= (chan == `ACC_CH_PORT_B_ONE);
         // Done rises in the same cycle as the internal flag and clears one cycle after it
         done_o             <= done_r | sar_done;
      end
   end
   // Port B pins keep their digital driver; only the select lines change

   acc_sar u_sar (
      .clk_i     (clk_i),
      .rst_n_i   (rst_n_i),
      .tick_i    (conv_tick_r),
      .start_i   (start_r),
      .ten_bit_i (ten_bit),
      .long_i    (long_s),
      .cmp_i     (cmp_i),
      .dac_o     (dac_o),
      .sample_o  (sample_o),
      .busy_o    (busy_o),
      .done_o    (sar_done),
      .result_o  (sar_res)
   );

endmodule
`default_nettype wire

// >>> verif/acc_cmp_model.sv
// Purpose: Comparator and analog source standing at the converter input
// Assumes: vin_i is the held analog level, ten bits of scale
// Notes:   Answers in the same cycle as the trial code
`timescale 1ns/1ps
`default_nettype none
module acc_cmp_model (
   input  wire logic [9:0] vin_i,
   input  wire logic [9:0] dac_i,
   output logic            cmp_o
);
   // High while the input is at or above the trial code
   // The pin is set as input, so no port driver disturbs vin_i
   assign cmp_o = (vin_i >= dac_i);
endmodule
`default_nettype wire

// >>> verif/acc_props_properties.sv
// Purpose: Port checks of the converter control block
// Assumes: The bus master holds each request until pready
// Notes:   Bound into acc_top
`timescale 1ns/1ps
`default_nettype none
module acc_props (
   input wire logic        clk_i,
   input wire logic        rst_n_i,
   input wire logic        psel_i,
   input wire logic        penable_i,
   input wire logic        pwrite_i,
   input wire logic [31:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [31:0] prdata_o,
   input wire logic        pready_o,
   input wire logic        pslverr_o,
   input wire logic        stop_i,
   input wire logic        cmp_i,
   input wire logic [4:0]  chan_sel_o,
   input wire logic        bandgap_sel_o,
   input wire logic [1:0]  port_b_analog_o,
   input wire logic [9:0]  dac_o,
   input wire logic        sample_o,
   input wire logic        busy_o,
   input wire logic        done_o
);
   // ==========================================================
   // Helpers
   default clocking @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);
   wire bad_a = (paddr_i[31:4] != 28'h0) || (paddr_i[1:0] != 2'h0);
   wire wr_sc = psel_i & penable_i & pready_o & pwrite_i & (paddr_i == 32'h0);
   // ==========================================================
   // Assertions
   chk_ready_pulse: assert property (pready_o |=> !pready_o)
      else $error("pready longer than one cycle");
   chk_ready_access: assert property (pready_o |-> psel_i && penable_i)
      else $error("pready outside access");
   chk_err_range: assert property (pready_o && bad_a |-> pslverr_o && prdata_o == 32'h0)
      else $error("bad address not refused");
   chk_err_ok: assert property (pready_o && !bad_a |-> !pslverr_o)
      else $error("good address refused");
   chk_bandgap_route: assert property (bandgap_sel_o == (chan_sel_o == 5'h1A))
      else $error("bandgap select wrong");
   chk_port_b_route: assert property (
      port_b_analog_o == {chan_sel_o == 5'h05, chan_sel_o == 5'h04})
      else $error("port b select wrong");
   chk_done_clear: assert property ($fell(done_o) |-> $past(wr_sc) || $past(wr_sc, 2))
      else $error("done cleared without write");
   chk_done_busy: assert property ($rose(done_o) |-> $past(busy_o) || $past(busy_o, 2))
      else $error("done without conversion");
   chk_start_busy: assert property (
      wr_sc && pwdata_i[4:0] != 5'h1F |-> ##[1:3] busy_o)
      else $error("conversion did not start");
   chk_sample_busy: assert property (sample_o |-> busy_o)
      else $error("sample outside conversion");
   cov_done: cover property ($rose(done_o));
   cov_err: cover property (pready_o && pslverr_o);
   cov_sample: cover property ($fell(sample_o) && busy_o);
endmodule
bind acc_top acc_props u_props (.*);
`default_nettype wire

// >>> verif/adc_conversion_control_test.sv
// Purpose: Register and conversion tests of the converter control block
// Assumes: Async clock divide set to 2 for a short run
// Notes:   Comparator model supplies the analog side
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin miscompares++; \
   $display("[ERR] %s exp %h got %h", n, e, g); end end
module adc_conversion_control_test;
   logic clk_i, rst_n_i, psel_i, penable_i, pwrite_i, stop_i, cmp_i;
   logic [31:0] paddr_i, pwdata_i, prdata_o, rd_q;
   logic pready_o, pslverr_o, bandgap_sel_o, sample_o, busy_o, done_o, err_q;
   logic [4:0] chan_sel_o;
   logic [1:0] port_b_analog_o;
   logic [9:0] dac_o, vin;
   int miscompares, cmp_count, c0, c1;
   acc_top #(.ASYNC_DIV(2)) dut (.*);
   acc_cmp_model u_cmp (.vin_i(vin), .dac_i(dac_o), .cmp_o(cmp_i));
   // ==========================================================
   // Tasks
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_i);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (pready_o !== 1'b1 && n < 50);
      rd_q = prdata_o;
      err_q = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      if (n >= 50) begin
         miscompares++;
         finish_test;
      end
   endtask
   task automatic wait_done(output int cyc);
      cyc = 0;
      repeat (2) @(posedge clk_i);
      while (done_o !== 1'b1 && cyc < 3000) begin
         @(posedge clk_i);
         cyc++;
      end
      if (cyc >= 3000) begin
         miscompares++;
         finish_test;
      end
   endtask
   task automatic start(input logic [7:0] ck, input logic [4:0] ch, input logic [9:0] v);
      vin <= v;
      apb(1'b1, 32'h4, {24'h0, ck});
      apb(1'b1, 32'h0, {27'h0, ch});
   endtask
   task automatic result(input logic [1:0] hi, input logic [7:0] lo);
      apb(1'b0, 32'h8, 32'h0);
      `CHK("res_high", {30'h0, hi}, rd_q)
      apb(1'b0, 32'hC, 32'h0);
      `CHK("res_low", {24'h0, lo}, rd_q)
      apb(1'b0, 32'h0, 32'h0);
      `CHK("done_bit", 1'b1, rd_q[7])
   endtask
   // ==========================================================
   // Sequence
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   initial begin
      {rst_n_i, psel_i, penable_i, pwrite_i, stop_i} = 5'h00;
      paddr_i = 32'h0;
      pwdata_i = 32'h0;
      vin = 10'h0;
      repeat (3) @(posedge clk_i);
      rst_n_i <= 1'b1;
      apb(1'b0, 32'h0, 32'h0);
      `CHK("sc_reset", 32'h1F, rd_q)
      apb(1'b0, 32'h4, 32'h0);
      `CHK("ck_reset", 32'h01, rd_q)
      `CHK("chan_reset", 5'h1F, chan_sel_o)
      apb(1'b0, 32'h10, 32'h0);
      `CHK("err_range", 2'b10, {err_q, |rd_q})
      apb(1'b1, 32'h6, 32'h3E);
      `CHK("err_align", 1'b1, err_q)
      apb(1'b1, 32'h4, 32'hFF);
      apb(1'b0, 32'h4, 32'h0);
      `CHK("ck_mask", 32'h3F, rd_q)
      $display("registers done");
      start(8'h01, 5'h04, 10'h2A5);
      wait_done(c0);
      result(2'h2, 8'hA5);
      `CHK("port_b0", 2'b01, port_b_analog_o)
      start(8'h03, 5'h05, 10'h2A5);
      wait_done(c1);
      result(2'h2, 8'hA5);
      `CHK("port_b1", 2'b10, port_b_analog_o)
      `CHK("long_extra", 16, c1 - c0)
      start(8'h00, 5'h1A, 10'h30D);
      wait_done(c0);
      result(2'h0, 8'hC3);
      `CHK("bandgap", 1'b1, bandgap_sel_o)
      $display("conversions done");
      stop_i <= 1'b1;
      start(8'h01, 5'h04, 10'h155);
      repeat (300) @(posedge clk_i);
      `CHK("stop_hold", 1'b0, done_o)
      stop_i <= 1'b0;
      wait_done(c0);
      result(2'h1, 8'h55);
      stop_i <= 1'b1;
      start(8'h0D, 5'h04, 10'h0AA);
      wait_done(c0);
      result(2'h0, 8'hAA);
      start(8'h05, 5'h05, 10'h3C3);
      wait_done(c0);
      result(2'h3, 8'hC3);
      `CHK("one_shot", 1'b0, busy_o)
      $display("stop mode done");
      apb(1'b1, 32'h0, 32'h25);
      wait_done(c0);
      repeat (2) @(posedge clk_i);
      `CHK("cont_restart", 1'b1, busy_o)
      apb(1'b1, 32'h0, 32'h1F);
      wait_done(c0);
      repeat (2) @(posedge clk_i);
      `CHK("cont_stop", 1'b0, busy_o)
      apb(1'b0, 32'hC, 32'h0);
      `CHK("cont_low", 32'hC3, rd_q)
      $display("continuous done");
      finish_test;
   end
endmodule
`default_nettype wire
